/* bcf_flow_ctrl.sv */
// Far branch and subroutine call flow controller with cycle accounting.
`timescale 1ns/1ns
// Overview of operation
// - Immediate far jump loads counter and page together.
// - Accumulator far jump uses low TGT_W accumulator bits.
// - Far jumps cost 4/2 or 6/4 cycles.
// - Push return address before counter is overwritten.
// - Call target: second word or accumulator low 16.
// - Non-delayed call discards two fetched words.
// - Delayed call runs the slot, no flush.
// - Calls cost 4/2 or 6/4 cycles.
// - Conditional call proceeds only when condition holds.
// - Non-delayed conditional flushes only when taken.
// - Delayed conditional always runs slot; condition independent.
// - Conditional call costs 5/3 or 3/3.
// - Page extension is seven bits wide.
// - Counter takes bits 15-0, page upper bits.
// - Sequential flow increments only the counter.
module bcf_flow_ctrl
   import bcf_pkg::*;
#(
   parameter int TGT_W = TARGET_W_FULL
)
(
   input  wire logic                      CLOCK,
   input  wire logic                      RST_N,
   input  wire logic                      OP_VALID,
   input  wire logic [2:0]                OP_KIND,
   input  wire logic                      OP_DELAYED,
   input  wire logic                      OP_ACC_SEL,
   input  wire logic [TARGET_W_FULL-1:0]  OP_OPERAND,
   input  wire logic [TARGET_W_FULL-1:0]  ACC_A,
   input  wire logic [TARGET_W_FULL-1:0]  ACC_B,
   input  wire logic                      COND_MET,
   input  wire logic                      SEQ_STEP,
   output logic                           BUSY,
   output logic                           FLUSH,
   output logic                           STACK_PUSH,
   output logic [PC_W-1:0]                STACK_DATA,
   output logic [PC_W-1:0]                PC,
   output logic [PAGE_W-1:0]              PAGE
);

   bcf_state_e                state_ff;
   bcf_state_e                nxt_state;
   logic [CNT_W-1:0]          cnt_ff;
   logic                      is_far_ff;
   logic                      taken_ff;
   logic [PC_W-1:0]           tgt_pc_ff;
   logic [PAGE_W-1:0]         tgt_page_ff;
   logic [PC_W-1:0]           ret_ff;
   logic                      push_ff;
   logic                      flush_ff;
   logic [PC_W-1:0]           pc_ff;
   logic [PAGE_W-1:0]         page_ff;
   bcf_kind_e                 op_kind;
   logic                      kind_ok;
   logic                      accept;
   logic                      last;
   logic                      is_far;
   logic                      is_call;
   logic                      taken;
   logic [TARGET_W_FULL-1:0]  acc_sel;
   logic [TARGET_W_FULL-1:0]  nxt_tgt;
   logic [PC_W-1:0]           nxt_ret;
   logic [PC_W-1:0]           op_len;

   bcf_cost_if cost_bus ();

   // Keeps only the target bits that the variant implements.
   function automatic logic [TARGET_W_FULL-1:0] clip_target(
      input logic [TARGET_W_FULL-1:0] t);
      logic [TARGET_W_FULL-1:0] r;
      r = '0;
      for (int i = 0; i < TGT_W; i++)
      begin
         r[i] = t[i];
      end
      return r;
   endfunction : clip_target

   // Decodes the presented operation.
   assign op_kind = bcf_kind_e'(OP_KIND);
   assign kind_ok = (OP_KIND <= K_CALL_CND);
   assign accept  = (state_ff == ST_IDLE) && OP_VALID && kind_ok;
   assign last    = (state_ff == ST_RUN) && (cnt_ff == CNT_ONE);
   assign is_far  = (op_kind == K_FAR_IMM) || (op_kind == K_FAR_ACC);
   assign is_call = !is_far;
   assign taken   = (op_kind != K_CALL_CND) || COND_MET;
   assign acc_sel = OP_ACC_SEL ? ACC_B : ACC_A;

   // Chooses the target and the return address of the operation.
   always_comb
   begin
      case (op_kind)
         K_FAR_IMM : nxt_tgt = clip_target(OP_OPERAND);
         K_FAR_ACC : nxt_tgt = clip_target(acc_sel);
         K_CALL_ACC : nxt_tgt = {{PAGE_W{1'b0}}, acc_sel[PC_W-1:0]};
         default : nxt_tgt = {{PAGE_W{1'b0}}, OP_OPERAND[PC_W-1:0]};
      endcase
      op_len  = (op_kind == K_FAR_ACC || op_kind == K_CALL_ACC) ? LEN_ACC : LEN_IMM;
      nxt_ret = pc_ff + op_len + (OP_DELAYED ? SLOT_WORDS : '0);
   end

   // The cost table turns operation, delay form and outcome into cycles.
   assign cost_bus.kind    = op_kind;
   assign cost_bus.delayed = OP_DELAYED;
   assign cost_bus.taken   = taken;

   bcf_cost_table u_cost (
      .cost (cost_bus)
   );

   // Next state of the controller.
   always_comb
   begin
      case (state_ff)
         ST_IDLE : nxt_state = accept ? ST_RUN : ST_IDLE;
         ST_RUN : nxt_state = last ? ST_IDLE : ST_RUN;
         default : nxt_state = ST_IDLE;
      endcase
   end

   // State register.
   always_ff @(posedge CLOCK)
   begin
      if (!RST_N)
         state_ff <= ST_IDLE;
      else
         state_ff <= nxt_state;
   end

   // Remaining cycle count; the accept cycle is the first of the cost.
   always_ff @(posedge CLOCK)
   begin
      if (!RST_N)
         cnt_ff <= '0;
      else if (accept)
         cnt_ff <= cost_bus.cycles - CNT_ONE;
      else if (state_ff == ST_RUN)
         cnt_ff <= cnt_ff - CNT_ONE;
   end

   // Captures target, outcome and return address when the operation is accepted.
   // The condition is sampled here, so slot instructions cannot change it.
   always_ff @(posedge CLOCK)
   begin
      if (!RST_N)
      begin
         is_far_ff   <= 1'b0;
         taken_ff    <= 1'b0;
         tgt_pc_ff   <= '0;
         tgt_page_ff <= PAGE_RESET;
         ret_ff      <= '0;
      end
      else if (accept)
      begin
         is_far_ff   <= is_far;
         taken_ff    <= taken;
         tgt_pc_ff   <= nxt_tgt[PC_W-1:0];
         tgt_page_ff <= nxt_tgt[TARGET_W_FULL-1:PC_W];
         ret_ff      <= nxt_ret;
      end
   end

   // Stack push strobe in the first run cycle, ahead of the counter load.
   always_ff @(posedge CLOCK)
   begin
      if (!RST_N)
         push_ff <= 1'b0;
      else
         push_ff <= accept && is_call && taken;
   end

   // Flush strobe: only non-delayed taken operations discard the two words.
   // Delayed forms rely on the slot holding no discontinuity.
   always_ff @(posedge CLOCK)
   begin
      if (!RST_N)
         flush_ff <= 1'b0;
      else
         flush_ff <= accept && !OP_DELAYED && taken;
   end

   // Program counter: target or fall-through at the end, else sequential step.
   always_ff @(posedge CLOCK)
   begin
      if (!RST_N)
         pc_ff <= PC_RESET;
      else if (last)
         pc_ff <= taken_ff ? tgt_pc_ff : ret_ff;
      else if ((state_ff == ST_IDLE) && !accept && SEQ_STEP)
         pc_ff <= pc_ff + PC_STEP;
   end

   // Page extension changes only on a far jump, never on sequential flow.
   always_ff @(posedge CLOCK)
   begin
      if (!RST_N)
         page_ff <= PAGE_RESET;
      else if (last && is_far_ff)
         page_ff <= tgt_page_ff;
   end

   // Outputs.
   assign BUSY       = (state_ff == ST_RUN);
   assign FLUSH      = flush_ff;
   assign STACK_PUSH = push_ff;
   assign STACK_DATA = ret_ff;
   assign PC         = pc_ff;
   assign PAGE       = page_ff;

   // Checks on the controller behaviour.
   default clocking dc @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   logic acc_fi;
   logic acc_fa;
   logic acc_cc;
   logic [PC_W-1:0] tgt16;
   assign acc_fi = accept && (op_kind == K_FAR_IMM);
   assign acc_fa = accept && (op_kind == K_FAR_ACC);
   assign acc_cc = accept && (op_kind == K_CALL_CND);
   assign tgt16  = nxt_tgt[PC_W-1:0];

   far_imm_cost_a: assert property (acc_fi && !OP_DELAYED |=> BUSY [*3] ##1 !BUSY)
      else $error("far immediate jump cost wrong");
   far_acc_cost_a: assert property (acc_fa && OP_DELAYED |=> BUSY [*3] ##1 !BUSY)
      else $error("delayed accumulator far jump cost wrong");
   far_imm_load_a: assert property (acc_fi && !OP_DELAYED |-> ##4
         (PC == $past(tgt16, 4)) && (PAGE == $past(nxt_tgt[TARGET_W_FULL-1:PC_W], 4)))
      else $error("far jump target not loaded");
   call_acc_cost_a: assert property (accept && op_kind == K_CALL_ACC && !OP_DELAYED
         |=> BUSY [*5] ##1 !BUSY)
      else $error("accumulator call cost wrong");
   push_before_load_a: assert property (STACK_PUSH |-> $stable(PC) ##1 BUSY || PC != $past(PC))
      else $error("push not ahead of counter load");
   push_data_a: assert property (accept && is_call && taken |=> STACK_PUSH
         && STACK_DATA == $past(nxt_ret))
      else $error("return address not pushed");
   cond_taken_cost_a: assert property (acc_cc && COND_MET && !OP_DELAYED
         |=> BUSY [*4] ##1 !BUSY)
      else $error("taken conditional call cost wrong");
   cond_skip_a: assert property (acc_cc && !COND_MET
         |=> !STACK_PUSH && !FLUSH ##1 BUSY ##1 !BUSY)
      else $error("untaken conditional call misbehaved");
   call_flush_a: assert property (accept && is_call && taken |=> FLUSH == !$past(OP_DELAYED))
      else $error("flush does not follow delay form");
   seq_page_a: assert property (state_ff == ST_IDLE && !accept && SEQ_STEP
         |=> $stable(PAGE) && PC == $past(PC) + PC_STEP)
      else $error("sequential step wrong");
   page_clip_a: assert property ((PAGE >> (TGT_W - PC_W)) == '0)
      else $error("unused page bits set");

   far_cover_c: cover property (acc_fa && !OP_DELAYED ##6 !BUSY);
   call_cover_c: cover property (accept && op_kind == K_CALL_IMM ##1 STACK_PUSH);
   cond_cover_c: cover property (acc_cc && OP_DELAYED && !COND_MET);

endmodule : bcf_flow_ctrl

/* bcf_pkg.sv */
// Shared constants and types for the branch and call flow controller.
package bcf_pkg;

   // Address widths of the program counter, page extension and largest target.
   localparam int TARGET_W_FULL = 23;
   localparam int PC_W          = 16;
   localparam int PAGE_W        = 7;
   localparam int CNT_W         = 3;

   // Reset values of the program counter and the page extension register.
   localparam logic [PC_W-1:0]   PC_RESET   = 16'hFF80;
   localparam logic [PAGE_W-1:0] PAGE_RESET = 7'h00;

   // Address steps: sequential step, word lengths and delay slot size.
   localparam logic [PC_W-1:0] PC_STEP    = 16'h0001;
   localparam logic [PC_W-1:0] LEN_IMM    = 16'h0002;
   localparam logic [PC_W-1:0] LEN_ACC    = 16'h0001;
   localparam logic [PC_W-1:0] SLOT_WORDS = 16'h0002;

   // Cycle costs of each operation.
   localparam logic [CNT_W-1:0] CYC_IMM_ND  = 3'h4;
   localparam logic [CNT_W-1:0] CYC_IMM_D   = 3'h2;
   localparam logic [CNT_W-1:0] CYC_ACC_ND  = 3'h6;
   localparam logic [CNT_W-1:0] CYC_ACC_D   = 3'h4;
   localparam logic [CNT_W-1:0] CYC_COND_T  = 3'h5;
   localparam logic [CNT_W-1:0] CYC_COND_NT = 3'h3;
   localparam logic [CNT_W-1:0] CYC_COND_D  = 3'h3;
   localparam logic [CNT_W-1:0] CNT_ONE     = 3'h1;

   // Flow operation codes presented by the decoder.
   typedef enum logic [2:0] {
      K_FAR_IMM  = 3'h0,
      K_FAR_ACC  = 3'h1,
      K_CALL_IMM = 3'h2,
      K_CALL_ACC = 3'h3,
      K_CALL_CND = 3'h4
   } bcf_kind_e;

   // Controller states, Gray coded.
   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_RUN  = 1'b1
   } bcf_state_e;

endpackage : bcf_pkg

/* bcf_cost_if.sv */
// Carrier between the flow controller and its cycle cost table.
`timescale 1ns/1ns
interface bcf_cost_if;
   import bcf_pkg::*;
   bcf_kind_e          kind;
   logic               delayed;
   logic               taken;
   logic [CNT_W-1:0]   cycles;
   modport ctrl (output kind, output delayed, output taken, input cycles);
   modport table_p (input kind, input delayed, input taken, output cycles);
endinterface : bcf_cost_if

/* bcf_cost_table.sv */
// Cycle cost table of the far branch and call operations.
`timescale 1ns/1ns
module bcf_cost_table
   import bcf_pkg::*;
(
   bcf_cost_if.table_p cost
);

   // Picks the cycle count from operation, delay form and condition result.
   always_comb
   begin
      case (cost.kind)
         K_FAR_IMM, K_CALL_IMM : cost.cycles = cost.delayed ? CYC_IMM_D : CYC_IMM_ND;
         K_FAR_ACC, K_CALL_ACC : cost.cycles = cost.delayed ? CYC_ACC_D : CYC_ACC_ND;
         K_CALL_CND :
            cost.cycles = cost.delayed ? CYC_COND_D :
                          (cost.taken ? CYC_COND_T : CYC_COND_NT);
         default : cost.cycles = CYC_IMM_D;
      endcase
   end

endmodule : bcf_cost_table

/* bcf_stack_model.sv */
// Data stack model that keeps every return address pushed by the controller.
`timescale 1ns/1ns
module bcf_stack_model
   import bcf_pkg::*;
(
   input  wire logic            clock,
   input  wire logic            rst_n,
   input  wire logic            push,
   input  wire logic [PC_W-1:0] data,
   output int                   depth
);
   logic [PC_W-1:0] mem_q[$];

   // Each push pulse stores the return address on top of the stack.
   always @(posedge clock)
   begin
      if (!rst_n)
      begin
         mem_q.delete();
      end
      else if (push === 1'b1)
      begin
         mem_q.push_back(data);
      end
      depth = mem_q.size();
   end
endmodule : bcf_stack_model

/* tb_top.sv */
// Self-checking testbench of the branch and call flow controller.
`timescale 1ns/1ns
module tb_top import bcf_pkg::*;;
   localparam int TW = 20;
   typedef struct {
      int cyc; logic fl; logic pu; logic [15:0] dat; logic [15:0] pc; logic [6:0] pg;
   } bcf_exp_s;

   logic        CLOCK = 1'b0;
   logic        RST_N = 1'b0;
   logic        OP_VALID = 1'b0;
   logic        OP_DELAYED = 1'b0;
   logic        OP_ACC_SEL = 1'b0;
   logic        COND_MET = 1'b0;
   logic        SEQ_STEP = 1'b0;
   logic [2:0]  OP_KIND = 3'h0;
   logic [22:0] OP_OPERAND = 23'h0;
   logic [22:0] ACC_A = 23'h0;
   logic [22:0] ACC_B = 23'h0;
   logic        BUSY, FLUSH, STACK_PUSH;
   logic [15:0] STACK_DATA, PC;
   logic [6:0]  PAGE;
   int          n_fail = 0, num_checks = 0, n_busy = 0, n_push = 0, depth;
   logic        s_fl = 1'b0, s_pu = 1'b0;
   logic [15:0] s_dat = 16'h0000, exp_pc;
   logic [6:0]  exp_pg;
   bcf_exp_s    exp_q[$], e;

   bcf_flow_ctrl #(.TGT_W(TW)) u_bcf_flow_ctrl (.CLOCK(CLOCK), .RST_N(RST_N),
      .OP_VALID(OP_VALID), .OP_KIND(OP_KIND), .OP_DELAYED(OP_DELAYED),
      .OP_ACC_SEL(OP_ACC_SEL), .OP_OPERAND(OP_OPERAND), .ACC_A(ACC_A), .ACC_B(ACC_B),
      .COND_MET(COND_MET), .SEQ_STEP(SEQ_STEP), .BUSY(BUSY), .FLUSH(FLUSH),
      .STACK_PUSH(STACK_PUSH), .STACK_DATA(STACK_DATA), .PC(PC), .PAGE(PAGE));

   bcf_stack_model u_bcf_stack_model (.clock(CLOCK), .rst_n(RST_N), .push(STACK_PUSH),
      .data(STACK_DATA), .depth(depth));

   // Core clock of 40 ns period.
   always #20 CLOCK = ~CLOCK;

   task automatic check(string name, logic [31:0] seen, logic [31:0] want);
      num_checks++;
      if (seen !== want)
      begin
         n_fail++;
         $display("unexpected %s: expected %0h seen %0h", name, want, seen);
      end
   endtask : check

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : final_report

   // Presents one operation, notes its expected outcome and waits for the end of its run.
   task automatic op(logic [2:0] k, logic d, logic c, logic hold);
      logic [22:0] t;
      logic        tk;
      bcf_exp_s    x;
      OP_KIND = k;
      OP_DELAYED = d;
      COND_MET = c;
      SEQ_STEP = 1'b0;
      OP_ACC_SEL = 1'($urandom);
      OP_OPERAND = 23'($urandom);
      ACC_A = 23'($urandom);
      ACC_B = 23'($urandom);
      OP_VALID = 1'b1;
      t = k[0] ? (OP_ACC_SEL ? ACC_B : ACC_A) : OP_OPERAND;
      t = t & ((23'h1 << TW) - 23'h1);
      tk = (k != 3'h4) || c;
      x.cyc = (k == 3'h4) ? (d ? CYC_COND_D : (c ? CYC_COND_T : CYC_COND_NT))
            : (k[0] ? (d ? CYC_ACC_D : CYC_ACC_ND) : (d ? CYC_IMM_D : CYC_IMM_ND));
      x.dat = exp_pc + (k[0] ? 16'h0001 : 16'h0002) + (d ? 16'h0002 : 16'h0000);
      x.pu = tk && k >= 3'h2;
      x.fl = tk && !d;
      x.pc = tk ? t[15:0] : x.dat;
      x.pg = (k < 3'h2) ? t[22:16] : exp_pg;
      exp_pc = x.pc;
      exp_pg = x.pg;
      n_push += int'(x.pu);
      exp_q.push_back(x);
      @(negedge CLOCK);
      // Optionally keep a stray request and a step request up while the run is busy.
      OP_VALID = hold;
      SEQ_STEP = hold;
      OP_KIND = 3'h0;
      OP_OPERAND = ~OP_OPERAND;
      for (int i = 0; i < 10 && BUSY !== 1'b0; i++)
         @(negedge CLOCK);
      if (BUSY !== 1'b0)
      begin
         check("busy wait", 32'h1, 32'h0);
         final_report();
      end
   endtask : op

   // Collects what one run shows and compares it with the oldest note when busy falls.
   always @(negedge CLOCK)
   begin
      if (BUSY === 1'b1)
      begin
         n_busy++;
         s_fl = s_fl | (FLUSH === 1'b1);
         s_pu = s_pu | (STACK_PUSH === 1'b1);
         if (STACK_PUSH === 1'b1)
            s_dat = STACK_DATA;
      end
      else if (n_busy != 0)
      begin
         e = exp_q.pop_front();
         check("cycles", n_busy + 1, e.cyc);
         check("flush", s_fl, e.fl);
         check("push", s_pu, e.pu);
         check("return", e.pu ? s_dat : 16'h0000, e.pu ? e.dat : 16'h0000);
         check("pc", PC, e.pc);
         check("page", PAGE, e.pg);
         n_busy = 0;
         s_fl = 1'b0;
         s_pu = 1'b0;
      end
   end

   // Reset, then every operation kind in every delayed and condition combination.
   initial
   begin
      void'($urandom(32'hA0C98A19));
      exp_pc = 16'hFF80;
      exp_pg = 7'h00;
      repeat (12) @(negedge CLOCK);
      RST_N = 1'b1;
      check("reset pc", PC, 16'hFF80);
      check("reset page", PAGE, 7'h00);
      for (int i = 0; i < 20; i++)
      begin
         if (i % 6 == 2)
         begin
            // An undefined operation kind is ignored, so the step still advances the counter.
            OP_VALID = 1'b1;
            OP_KIND = 3'(5 + $urandom_range(2));
            SEQ_STEP = 1'b1;
            repeat (2) @(negedge CLOCK);
            exp_pc = exp_pc + 16'h0002;
            check("step busy", BUSY, 1'b0);
            check("step pc", PC, exp_pc);
            check("step page", PAGE, exp_pg);
         end
         // Each operation follows the previous one after its run has ended and busy has fallen.
         op(3'(i % 5), 1'((i / 5) % 2), 1'((i / 10) % 2), i % 3 == 0);
      end
      repeat (2) @(negedge CLOCK);
      check("stack depth", depth, n_push);
      check("pending", exp_q.size(), 32'h0);
      final_report();
   end
endmodule : tb_top
